/* File: hw/aps_pkg.sv */
// Constants shared by the presample sequencer, its checker, core model and bench.
// Assumes a 25 MHz system clock and a plain strobe register port.
package aps_pkg;
  localparam int NUM_CH      = 16;
  localparam int CH_W        = 4;
  localparam int DATA_W      = 12;
  localparam int MOD_ID_W    = 2;
  // Register offsets
  localparam logic [7:0] ADDR_ENABLE   = 8'h00; // presample_enable_reg
  localparam logic [7:0] ADDR_CONTROL  = 8'h04; // presample_control_reg
  localparam logic [7:0] ADDR_SELECT   = 8'h08; // channel select mask
  localparam logic [7:0] ADDR_START    = 8'h0C; // start and status
  localparam logic [7:0] ADDR_QRIGHT   = 8'h10; // queue_right_aligned_read
  localparam logic [7:0] ADDR_QLEFT    = 8'h14; // queue_left_aligned_read
  localparam logic [7:0] ADDR_PADEN    = 8'h18; // pad input enables
  localparam logic [7:0] ADDR_RESULT0  = 8'h40; // channel_result_reg base
  // Control register fields
  localparam int CTL_REF_BIT    = 0; // presample_ref_select
  localparam int CTL_BYPASS_BIT = 1; // presample_convert_bypass
  localparam int CTL_XTRIG_BIT  = 2; // cross-trigger mode
  // Channel result register fields
  localparam int RES_VALID_BIT  = 31;
  localparam int RES_STAT_LSB   = 16;
  localparam logic [1:0] STAT_PAD    = 2'h0;
  localparam logic [1:0] STAT_REF    = 2'h1;
  localparam logic [1:0] STAT_OPEN   = 2'h2;
  // Queue entry fields
  localparam int Q_CH_LSB       = 16;
  localparam int Q_MOD_LSB      = 24;
  // Phase timing
  localparam int PRESAMPLE_NS   = 240;
  localparam int SAMPLE_NS      = 480;
  localparam int CONVERT_NS     = 520;
  localparam int CLK_NS         = 40;
  localparam int PRESAMPLE_CYC  = (PRESAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_CYC     = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONVERT_CYC    = (CONVERT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W          = 8;
  // Capacitor source selection
  typedef enum logic [1:0] {
    APS_SRC_NONE = 2'b00,
    APS_SRC_VREFH = 2'b01,
    APS_SRC_VREFL = 2'b10,
    APS_SRC_PAD  = 2'b11
  } aps_src_t;
  typedef enum logic [1:0] {
    APS_IDLE     = 2'b00,
    APS_PRESAMP  = 2'b01,
    APS_SAMPLE   = 2'b10,
    APS_CONVERT  = 2'b11
  } aps_state_t;
endpackage

/* File: hw/aps_stream_if.sv */
// Valid/ready word carrier between sequencer and result buffer.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
interface aps_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface // aps_stream_if

/* File: hw/aps_buf2.sv */
// Two-entry skid buffer for tagged queue words.
// Assumes synchronous active-high reset and one clock.
`timescale 1ns/10ps
module aps_buf2 #(
  parameter int W = 32
) (
  input  wire logic   clk,
  input  wire logic   rst,
  aps_stream_if.sink  in_s,
  output logic        out_valid,
  input  wire logic   out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  // Handshakes
  assign in_s.ready = (cnt_r != 2'd2);
  assign out_valid  = (cnt_r != 2'd0);
  assign push       = in_s.valid & in_s.ready;
  assign pop        = out_valid & out_ready;
  assign out_data   = mem_r[rp_r];

  // Storage writes
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_s.data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop)  rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // aps_buf2

/* File: hw/aps_seq.sv */
// Presample / sample / convert channel sequencer with result storage.
// Results go to per-channel registers or a tagged two-entry queue.
// Assumes an external SAR core answering on conv_done with conv_data.
// Assumes one clock, sync active-high reset and synchronous inputs.
// Register port never stalls; read data follow the strobe by a cycle.
// Behaviour
// - Each selected channel runs presample, sample, convert, then next channel.
// - Presample connects capacitor to internal reference, not the pad.
// - Sample connects capacitor to the selected pad through the multiplexer.
// - Convert turns the most recently sampled value into a result.
// - Presampling is enabled per channel by a bit in a config register.
// - A reference select picks high reference or reference ground.
// - Bypass set skips pad sampling and converts the presampled reference.
// - CPU mode writes per-channel result with valid, status and value.
// - Cross-trigger mode pushes each sample with its channel into a queue.
// - Queue entries carry data, channel, module id; right and left reads.
// - A disabled pad input is an open path; result keeps the reference.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module aps_seq #(
  parameter int              NUM_CH = aps_pkg::NUM_CH,
  parameter logic [1:0]      MOD_ID = 2'h1 // Arbitrary module identity
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  input  wire logic          xtrig_start,
  output aps_pkg::aps_src_t  cap_src,
  output logic [3:0]         mux_ch,
  output logic               conv_start,
  input  wire logic          conv_done,
  input  wire logic [11:0]   conv_data,
  output logic               busy
);
  //--------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------
  localparam int CW = aps_pkg::CH_W;
  localparam int DW = aps_pkg::DATA_W;

  // Sequencer state
  aps_pkg::aps_state_t state_r;

  // Software configuration
  logic [NUM_CH-1:0]   pre_en_r;
  logic [NUM_CH-1:0]   sel_r;
  logic [NUM_CH-1:0]   pad_en_r;
  logic                ref_sel_r;
  logic                bypass_r;
  logic                xmode_r;

  // Current channel, phase timing and capacitor history
  logic [CW-1:0]       ch_r;
  logic [aps_pkg::CNT_W-1:0] cnt_r;
  logic                conv_wait_r;
  logic                run_xmode_r;
  logic                cap_ref_r;

  // Per-channel results for CPU mode
  logic [DW-1:0]       res_data_r [NUM_CH];
  logic [1:0]          res_stat_r [NUM_CH];
  logic [NUM_CH-1:0]   res_valid_r;

  // Read path
  logic [31:0]         rdata_r;

  // Combinational helpers
  logic                start_req;
  logic                done_ev;
  logic [CW-1:0]       next_ch;
  logic                have_next;

  // Queue side and result status
  logic                q_valid;
  logic                q_ready;
  logic [31:0]         q_data;
  logic [1:0]          cur_stat;
  aps_stream_if #(.W(32)) q_if ();

  //--------------------------------------------------------------
  // Register writes
  //--------------------------------------------------------------
  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      // Nothing selected or enabled until software writes
      pre_en_r  <= '0;
      sel_r     <= '0;
      pad_en_r  <= '0;
      ref_sel_r <= 1'b0;
      bypass_r  <= 1'b0;
      xmode_r   <= 1'b0;
    end else if (reg_wr) begin
      // Unmapped offsets fall to default and are dropped
      unique case (reg_addr)
        aps_pkg::ADDR_ENABLE: pre_en_r <= reg_wdata[NUM_CH-1:0];
        aps_pkg::ADDR_SELECT: sel_r    <= reg_wdata[NUM_CH-1:0];
        aps_pkg::ADDR_PADEN:  pad_en_r <= reg_wdata[NUM_CH-1:0];
        aps_pkg::ADDR_CONTROL: begin
          ref_sel_r <= reg_wdata[aps_pkg::CTL_REF_BIT];
          bypass_r  <= reg_wdata[aps_pkg::CTL_BYPASS_BIT];
          xmode_r   <= reg_wdata[aps_pkg::CTL_XTRIG_BIT];
        end
        default: ;
      endcase
    end
  end

  // Start from software in CPU mode, from cross trigger otherwise
  // A start while busy is dropped by the idle-only check below
  assign start_req = xmode_r ? xtrig_start
                   : (reg_wr && reg_addr == aps_pkg::ADDR_START &&
                      reg_wdata[0]);

  //--------------------------------------------------------------
  // Channel walk
  //--------------------------------------------------------------
  // Next selected channel above the current one
  // Scans down so the lowest index above wins; none means last
  always_comb begin
    next_ch   = '0;
    have_next = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (sel_r[i] && (i > int'(ch_r))) begin
        next_ch   = CW'(i);
        have_next = 1'b1;
      end
    end
  end

  // Conversion finished; the core holds conv_done until consumed
  // Queue space is checked separately so cross mode can stall
  assign done_ev = (state_r == aps_pkg::APS_CONVERT) && conv_wait_r &&
                   conv_done;

  // Phase sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      // Back to idle with no conversion pending
      state_r     <= aps_pkg::APS_IDLE;
      ch_r        <= '0;
      cnt_r       <= '0;
      conv_wait_r <= 1'b0;
      run_xmode_r <= 1'b0;
      cap_ref_r   <= 1'b0;
    end else begin
      unique case (state_r)
        aps_pkg::APS_IDLE: begin
          // Needs a start and at least one selected channel
          if (start_req && sel_r != '0) begin
            run_xmode_r <= xmode_r;
            ch_r        <= '0;
            // Start at lowest selected channel
            for (int i = NUM_CH - 1; i >= 0; i--) begin
              if (sel_r[i]) ch_r <= CW'(i);
            end
            state_r <= aps_pkg::APS_PRESAMP;
            cnt_r   <= '0;
          end
        end

        aps_pkg::APS_PRESAMP: begin
          // Skip phase if channel has presampling disabled
          if (!pre_en_r[ch_r]) begin
            cap_ref_r <= 1'b0;
            state_r   <= aps_pkg::APS_SAMPLE;
            cnt_r     <= '0;
          end else if (cnt_r == aps_pkg::CNT_W'(aps_pkg::PRESAMPLE_CYC-1))
          begin
            cap_ref_r <= 1'b1;
            cnt_r     <= '0;
            // Bypass goes straight to conversion of the reference
            state_r <= bypass_r ? aps_pkg::APS_CONVERT
                                : aps_pkg::APS_SAMPLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end

        aps_pkg::APS_SAMPLE: begin
          if (cnt_r == aps_pkg::CNT_W'(aps_pkg::SAMPLE_CYC-1)) begin
            // Disabled pad leaves the capacitor on the reference
            if (pad_en_r[ch_r]) cap_ref_r <= 1'b0;
            cnt_r   <= '0;
            state_r <= aps_pkg::APS_CONVERT;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end

        aps_pkg::APS_CONVERT: begin
          // One start pulse, then wait for the core
          // Cross mode holds here while the queue is full
          if (!conv_wait_r) begin
            conv_wait_r <= 1'b1;
          end else if (done_ev && (!run_xmode_r || q_ready)) begin
            conv_wait_r <= 1'b0;
            cnt_r       <= '0;
            if (have_next) begin
              ch_r    <= next_ch;
              state_r <= aps_pkg::APS_PRESAMP;
            end else begin
              state_r <= aps_pkg::APS_IDLE;
            end
          end
        end

        default: state_r <= aps_pkg::APS_IDLE;
      endcase
    end
  end

  //--------------------------------------------------------------
  // Analog control outputs
  //--------------------------------------------------------------
  // Capacitor source per phase
  always_comb begin
    cap_src = aps_pkg::APS_SRC_NONE;
    unique case (state_r)
      // Presample: chosen reference, only when enabled
      aps_pkg::APS_PRESAMP:
        if (pre_en_r[ch_r])
          cap_src = ref_sel_r ? aps_pkg::APS_SRC_VREFL
                              : aps_pkg::APS_SRC_VREFH;
      // Sample: pad when its input is enabled, else float
      aps_pkg::APS_SAMPLE:
        cap_src = pad_en_r[ch_r] ? aps_pkg::APS_SRC_PAD
                                 : aps_pkg::APS_SRC_NONE;
      default: cap_src = aps_pkg::APS_SRC_NONE;
    endcase
  end

  // Multiplexer follows the current channel
  assign mux_ch     = ch_r;

  // One-cycle start on entering convert
  assign conv_start = (state_r == aps_pkg::APS_CONVERT) && !conv_wait_r;

  // Busy comes from the state register alone
  assign busy       = (state_r != aps_pkg::APS_IDLE);

  // Result status: disabled pad reads as open unless bypassed
  // A floating capacitor never reports as a pad value
  assign cur_stat = (!pad_en_r[ch_r] && !(bypass_r && cap_ref_r))
                  ? aps_pkg::STAT_OPEN
                  : cap_ref_r ? aps_pkg::STAT_REF
                  : aps_pkg::STAT_PAD;

  //--------------------------------------------------------------
  // CPU-mode result registers
  //--------------------------------------------------------------
  // Store result; a read of the register clears valid, set wins
  // Data and status are not reset; valid qualifies them
  always_ff @(posedge clk) begin
    if (rst) begin
      res_valid_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (done_ev && !run_xmode_r && ch_r == CW'(i)) begin
          res_valid_r[i] <= 1'b1;
          res_data_r[i]  <= conv_data;
          res_stat_r[i]  <= cur_stat;
        end else if (reg_rd &&
                     reg_addr == aps_pkg::ADDR_RESULT0 + 8'(4 * i)) begin
          res_valid_r[i] <= 1'b0;
        end
      end
    end
  end

  //--------------------------------------------------------------
  // Cross-trigger queue
  //--------------------------------------------------------------
  // Tagged word: module id, channel, data
  // Unused bits are zero; tags sit on nibble boundaries
  assign q_if.valid = done_ev && run_xmode_r;
  assign q_if.data  = {6'h00, MOD_ID, 4'h0, ch_r, 4'h0, conv_data};

  // In cross mode a full buffer stalls the sequencer in convert
  assign q_ready    = q_if.ready;

  // Either aligned view pops the oldest word
  aps_buf2 #(.W(32)) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_s      (q_if),
    .out_valid (q_valid),
    .out_ready (reg_rd && (reg_addr == aps_pkg::ADDR_QRIGHT ||
                           reg_addr == aps_pkg::ADDR_QLEFT)),
    .out_data  (q_data)
  );

  //--------------------------------------------------------------
  // Register reads
  //--------------------------------------------------------------
  // Read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= '0;
      // Result window: one word per channel from the base
      if (reg_addr >= aps_pkg::ADDR_RESULT0 &&
          reg_addr < aps_pkg::ADDR_RESULT0 + 8'(4 * NUM_CH) &&
          reg_addr[1:0] == 2'b00) begin
        rdata_r[aps_pkg::RES_VALID_BIT] <= res_valid_r[reg_addr[5:2]];
        rdata_r[aps_pkg::RES_STAT_LSB +: 2] <= res_stat_r[reg_addr[5:2]];
        rdata_r[DW-1:0] <= res_data_r[reg_addr[5:2]];
      end else begin
        // Configuration, status and queue views
        unique case (reg_addr)
          aps_pkg::ADDR_ENABLE:  rdata_r[NUM_CH-1:0] <= pre_en_r;
          aps_pkg::ADDR_SELECT:  rdata_r[NUM_CH-1:0] <= sel_r;
          aps_pkg::ADDR_PADEN:   rdata_r[NUM_CH-1:0] <= pad_en_r;
          aps_pkg::ADDR_CONTROL: rdata_r[2:0] <= {xmode_r, bypass_r,
                                                  ref_sel_r};
          aps_pkg::ADDR_START:   rdata_r[1:0] <= {q_valid, busy};
          aps_pkg::ADDR_QRIGHT:
            rdata_r <= q_valid ? {1'b1, q_data[30:0]} : 32'h0000_0000;
          aps_pkg::ADDR_QLEFT:
            rdata_r <= q_valid ? {q_data[11:0], 4'h0,
                                  1'b1, q_data[30:16]} : 32'h0000_0000;
          default: ;
        endcase
      end
    end else begin
      // Zero outside the answer cycle so stale data never shows
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;
endmodule // aps_seq

/* File: tb/aps_seq_asserts.sv */
// Port checker for the presample sequencer.
// Assumes a bind onto aps_seq; sync active-high reset.
`timescale 1ns/10ps
module aps_seq_chk (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [7:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire aps_pkg::aps_src_t cap_src,
  input wire logic [3:0]        mux_ch,
  input wire logic              conv_start,
  input wire logic              busy
);
  logic [2:0]  ctl_r;
  logic [15:0] sel_r;
  logic        pre;
  logic [7:0]  pad_cnt_r;
  // ----------------------------------------
  // Shadow of control and select writes
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_r <= 3'h0;
      sel_r <= 16'h0000;
    end else if (reg_wr && reg_addr == aps_pkg::ADDR_CONTROL) begin
      ctl_r <= reg_wdata[2:0];
    end else if (reg_wr && reg_addr == aps_pkg::ADDR_SELECT) begin
      sel_r <= reg_wdata[15:0];
    end
  end
  // Capacitor on a reference
  assign pre = cap_src == aps_pkg::APS_SRC_VREFH ||
               cap_src == aps_pkg::APS_SRC_VREFL;
  // Consecutive cycles with the pad on the capacitor
  always_ff @(posedge clk) begin
    if (rst || cap_src != aps_pkg::APS_SRC_PAD) begin
      pad_cnt_r <= 8'h00;
    end else if (pad_cnt_r != 8'hFF) begin
      pad_cnt_r <= pad_cnt_r + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_pre_len;
    pre && !$past(pre) |-> pre [*6] ##1 !pre;
  endproperty
  a_pre_len: assert property (p_pre_len)
    else $error("presample length wrong");
  property p_ref;
    pre |-> cap_src == (ctl_r[0] ? aps_pkg::APS_SRC_VREFL
                                 : aps_pkg::APS_SRC_VREFH);
  endproperty
  a_ref: assert property (p_ref)
    else $error("presample reference wrong");
  property p_samp_len;
    cap_src != aps_pkg::APS_SRC_PAD && pad_cnt_r != 8'h00
      |-> pad_cnt_r == 8'h0C && conv_start;
  endproperty
  a_samp_len: assert property (p_samp_len)
    else $error("sample phase wrong");
  property p_bypass;
    $fell(pre) && ctl_r[1] |-> conv_start;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass did not convert");
  property p_nobypass;
    $fell(pre) && !ctl_r[1] |-> !conv_start;
  endproperty
  a_nobypass: assert property (p_nobypass)
    else $error("sampling skipped");
  property p_conv_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse)
    else $error("convert start too long");
  property p_mux_stable;
    cap_src == aps_pkg::APS_SRC_PAD && $past(cap_src == aps_pkg::APS_SRC_PAD)
      |-> $stable(mux_ch);
  endproperty
  a_mux_stable: assert property (p_mux_stable)
    else $error("channel moved in sample");
  property p_idle;
    !busy |-> cap_src == aps_pkg::APS_SRC_NONE && !conv_start;
  endproperty
  a_idle: assert property (p_idle)
    else $error("activity while idle");
  property p_start;
    reg_wr && reg_addr == aps_pkg::ADDR_START && reg_wdata[0] && !busy &&
      sel_r != 16'h0000 && !ctl_r[2] |=> busy;
  endproperty
  a_start: assert property (p_start)
    else $error("start not taken");
  property p_rd;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read data outside slot");
endmodule // aps_seq_chk

/* File: tb/aps_sar_model.sv */
// Converter core and pads model beside the sequencer.
// Assumes one clock; dly sets conversion cycles.
`timescale 1ns/10ps
module aps_sar_model (
  input wire logic              clk,
  input wire logic              rst,
  input wire aps_pkg::aps_src_t cap_src,
  input wire logic [3:0]        mux_ch,
  input wire logic              conv_start,
  input wire logic              busy,
  input wire logic [7:0]        dly,
  output logic                  conv_done,
  output logic [11:0]           conv_data
);
  logic [11:0] held_r;
  logic [7:0]  cnt_r;
  logic [3:0]  ch_r;
  logic        run_r;
  // Capacitor follows its source, floats when none
  always_ff @(posedge clk) begin
    if (cap_src == aps_pkg::APS_SRC_VREFH) held_r <= 12'hFFF;
    else if (cap_src == aps_pkg::APS_SRC_VREFL) held_r <= 12'h000;
    else if (cap_src == aps_pkg::APS_SRC_PAD) held_r <= {8'h5A, mux_ch};
  end
  // Done held until the sequencer moves on
  always_ff @(posedge clk) begin
    if (rst || !busy || (conv_done && mux_ch != ch_r)) begin
      run_r     <= 1'b0;
      conv_done <= 1'b0;
    end else if (conv_start) begin
      run_r     <= 1'b1;
      cnt_r     <= dly;
      ch_r      <= mux_ch;
      conv_done <= 1'b0;
    end else if (run_r && cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else if (run_r) begin
      conv_done <= 1'b1;
    end
  end
  // Stale data shows inverted
  assign conv_data = conv_done ? held_r : ~held_r;
endmodule // aps_sar_model

/* File: tb/tb_aps_seq.sv */
// Bench for the presample sequencer: register tasks and scenarios.
// Assumes the core model and the port checker bound below.
`timescale 1ns/10ps
module tb_aps_seq;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        xtrig_start = 1'b0;
  logic [7:0]  dly = 8'h01;
  logic [31:0] reg_rdata;
  aps_pkg::aps_src_t cap_src;
  logic [3:0]  mux_ch;
  logic        conv_start;
  logic        conv_done;
  logic        busy;
  logic [11:0] conv_data;
  logic [3:0]  convq[$];
  logic [31:0] d;
  int          error_cnt = 0;
  int          checked = 0;
  logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};
  logic        rs[3] = '{1'b0, 1'b1, 1'b0};
  localparam logic [1:0] MID = 2'h2; // Arbitrary module identity

  always #20 clk = ~clk;
  aps_seq #(.MOD_ID(MID)) aps_seq_i (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xtrig_start(xtrig_start),
    .cap_src(cap_src), .mux_ch(mux_ch), .conv_start(conv_start),
    .conv_done(conv_done), .conv_data(conv_data), .busy(busy));
  aps_sar_model aps_sar_model_i (.clk(clk), .rst(rst), .cap_src(cap_src),
    .mux_ch(mux_ch), .conv_start(conv_start), .busy(busy), .dly(dly),
    .conv_done(conv_done), .conv_data(conv_data));
  // Record channel of each conversion
  always @(posedge clk) if (conv_start) convq.push_back(mux_ch);
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) chk(32'h1, 32'h0);
  endtask
  task automatic acq(input logic [15:0] s, input logic [2:0] c,
                     input logic [15:0] p);
    wr(aps_pkg::ADDR_SELECT, {16'h0, s});
    wr(aps_pkg::ADDR_CONTROL, {29'h0, c});
    wr(aps_pkg::ADDR_ENABLE, {16'h0, p});
    wr(aps_pkg::ADDR_START, 32'h1);
    wait_idle();
  endtask
  function automatic logic [31:0] res(logic [1:0] s, logic [11:0] v);
    return {1'b1, 13'h0, s, 4'h0, v};
  endfunction
  task automatic wrap_up;
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(d, 32'h0);
    end
    wr(aps_pkg::ADDR_PADEN, 32'h0000FFFF);
    acq(16'h0001, 3'h0, 16'h0001);
    rd(aps_pkg::ADDR_RESULT0);
    chk(d, res(aps_pkg::STAT_PAD, 12'h5A0));
    rd(aps_pkg::ADDR_RESULT0);
    chk({31'h0, d[31]}, 32'h0);
    // Three conversions of one input must agree
    for (int k = 0; k < 3; k++) begin
      acq(16'h0001, 3'h0, 16'h0000);
      rd(aps_pkg::ADDR_RESULT0);
      chk(d, res(aps_pkg::STAT_PAD, 12'h5A0));
    end
    // Short test: bypass converts high then ground
    for (int r = 0; r < 2; r++) begin
      acq(16'h0008, 3'h2 + 3'(r), 16'h0008);
      rd(aps_pkg::ADDR_RESULT0 + 8'h0C);
      chk(d, res(aps_pkg::STAT_REF, r ? 12'h000 : 12'hFFF));
    end
    // Open test on a disabled pad: high, ground, high
    wr(aps_pkg::ADDR_PADEN, 32'h0000FFFB);
    foreach (rs[i]) begin
      acq(16'h0004, {2'h0, rs[i]}, 16'h0004);
      rd(aps_pkg::ADDR_RESULT0 + 8'h08);
      chk(d, res(aps_pkg::STAT_OPEN, rs[i] ? 12'h000 : 12'hFFF));
    end
    wr(aps_pkg::ADDR_PADEN, 32'h0000FFFF);
    // Two channels, slow core, restart ignored
    dly <= 8'h14;
    convq.delete();
    wr(aps_pkg::ADDR_SELECT, 32'h12);
    wr(aps_pkg::ADDR_ENABLE, 32'h0);
    wr(aps_pkg::ADDR_START, 32'h1);
    wr(aps_pkg::ADDR_START, 32'h1);
    wait_idle();
    chk(32'(convq.size()), 32'h2);
    chk({28'h0, convq[0]}, 32'h1);
    chk({28'h0, convq[1]}, 32'h4);
    rd(aps_pkg::ADDR_RESULT0 + 8'h04);
    chk(d, res(aps_pkg::STAT_PAD, 12'h5A1));
    rd(aps_pkg::ADDR_RESULT0 + 8'h10);
    chk(d, res(aps_pkg::STAT_PAD, 12'h5A4));
    // Cross mode: three words into a two-entry queue
    dly <= 8'h01;
    convq.delete();
    wr(aps_pkg::ADDR_SELECT, 32'hE0);
    wr(aps_pkg::ADDR_CONTROL, 32'h4);
    @(posedge clk);
    xtrig_start <= 1'b1;
    @(posedge clk);
    xtrig_start <= 1'b0;
    for (int n = 0; n < 500 && convq.size() < 3; n++) @(posedge clk);
    repeat (40) @(posedge clk);
    chk({31'h0, busy}, 32'h1);
    rd(aps_pkg::ADDR_QRIGHT);
    chk(d, {1'b1, 5'h0, MID, 4'h0, 4'h5, 4'h0, 12'h5A5});
    rd(aps_pkg::ADDR_QLEFT);
    chk(d, {12'h5A6, 4'h0, 1'b1, 5'h0, MID, 4'h0, 4'h6});
    wait_idle();
    rd(aps_pkg::ADDR_QRIGHT);
    chk(d, {1'b1, 5'h0, MID, 4'h0, 4'h7, 4'h0, 12'h5A7});
    rd(aps_pkg::ADDR_START);
    chk(d, 32'h0);
    // Channel 5 again through a result register, as through the queue
    acq(16'h0020, 3'h0, 16'h0000);
    rd(aps_pkg::ADDR_RESULT0 + 8'h14);
    chk(d, res(aps_pkg::STAT_PAD, 12'h5A5));
    wrap_up();
  end
endmodule // tb_aps_seq

bind aps_seq aps_seq_chk aps_seq_chk_i (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_src(cap_src),
  .mux_ch(mux_ch), .conv_start(conv_start), .busy(busy));
